/* File: design/lnecfg_lane_regs.sv */
/*
 * Lane 3 equalizer configuration register pair: gain control at 0x0b and
 * stage enables at 0x0c, with the analog control outputs they steer.
 * Assumes a serial register slave on clk_sys_i presents one-cycle read and
 * write strobes with an offset and data; the serial protocol lives there.
 */
`timescale 1ns/100ps
`include "lnecfg_cfg.svh"

module lnecfg_lane_regs
    import lnecfg_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    input  wire logic [ADDR_W-1:0]        reg_addr_i,
    input  wire logic                     reg_wr_i,
    input  wire logic [7:0]               reg_wdata_i,
    input  wire logic                     reg_rd_i,
    output logic [7:0]                    reg_rdata_o,
    output logic                          reg_ack_o,
    output logic                          reg_err_o,
    output logic [2:0]                    equalizer_strength_o,
    output logic                          tx_dc_boost_o,
    output logic                          equalizer_dc_level_o,
    output logic [1:0]                    rx_gain_code_o,
    output lnecfg_pkg::lnecfg_rx_level_t  rx_gain_level_o,
    output logic                          rx_gain_pin_low_o,
    output logic                          rx_gain_pin_mid_o,
    output logic                          rx_gain_pin_high_o,
    output logic                          driver_ac_peaking_o,
    output logic                          equalizer_stage_off_o,
    output logic                          driver_stage_off_o
);
    import lnecfg_pkg::*;

    generate
        if (ADDR_W < 4 || ADDR_W > 8)
        begin : g_bad_width
            $error("ADDR_W must lie between 4 and 8");
        end
    endgenerate

    lnecfg_byte_t      gain_ctrl_r;
    lnecfg_byte_t      gain_ctrl_nxt;
    lnecfg_byte_t      stage_en_r;
    lnecfg_byte_t      stage_en_nxt;
    lnecfg_byte_t      rdata_nxt;
    logic [7:0]        addr_full;
    logic              hit_ctrl;
    logic              hit_en;
    logic              hit_any;
    logic              access;

    assign addr_full = 8'(reg_addr_i);
    assign hit_ctrl  = (addr_full == `LNECFG_ADDR_GAIN_CTRL);
    assign hit_en    = (addr_full == `LNECFG_ADDR_STAGE_EN);
    assign hit_any   = hit_ctrl | hit_en;
    assign access    = reg_wr_i | reg_rd_i;

    // all eight control bits are stored, reserved bit 7 and code 10 included
    assign gain_ctrl_nxt = (reg_wr_i && hit_ctrl) ? reg_wdata_i : gain_ctrl_r;

    // only the three low enable bits are storage; upper bits stay zero
    assign stage_en_nxt = (reg_wr_i && hit_en) ? (reg_wdata_i & `LNECFG_EN_WMASK)
                                               : stage_en_r;

    // a read in the same cycle as a write returns the value before the write
    assign rdata_nxt = !reg_rd_i ? 8'h00 :
                       hit_ctrl  ? gain_ctrl_r :
                       hit_en    ? stage_en_r :
                                   `LNECFG_UNMAPPED_DATA;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            gain_ctrl_r <= `LNECFG_GAIN_CTRL_RST;
            stage_en_r  <= `LNECFG_STAGE_EN_RST;
        end
        else
        begin
            gain_ctrl_r <= gain_ctrl_nxt;
            stage_en_r  <= stage_en_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_ack_o   <= 1'b0;
            reg_err_o   <= 1'b0;
        end
        else
        begin
            reg_rdata_o <= rdata_nxt;
            reg_ack_o   <= access;
            reg_err_o   <= access & ~hit_any;
        end
    end

    // analog controls come straight off the register flops
    assign equalizer_strength_o  = gain_ctrl_r[`LNECFG_CTL_EQ_MSB:`LNECFG_CTL_EQ_LSB];
    assign tx_dc_boost_o         = gain_ctrl_r[`LNECFG_CTL_TXB_BIT];
    // resets to -6 dB; software is expected to raise it for unity gain
    assign equalizer_dc_level_o  = gain_ctrl_r[`LNECFG_CTL_EQDC_BIT];
    assign rx_gain_code_o        = gain_ctrl_r[`LNECFG_CTL_RX_MSB:`LNECFG_CTL_RX_LSB];
    assign driver_ac_peaking_o   = stage_en_r[`LNECFG_EN_PEAK_BIT];
    assign equalizer_stage_off_o = stage_en_r[`LNECFG_EN_EQOFF_BIT];
    assign driver_stage_off_o    = stage_en_r[`LNECFG_EN_DRVOFF_BIT];

    lnecfg_rx_gain_dec u_rx_gain_dec (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .code_i     (gain_ctrl_r[`LNECFG_CTL_RX_MSB:`LNECFG_CTL_RX_LSB]),
        .level_o    (rx_gain_level_o),
        .pin_low_o  (rx_gain_pin_low_o),
        .pin_mid_o  (rx_gain_pin_mid_o),
        .pin_high_o (rx_gain_pin_high_o)
    );

    default clocking cb_sys @(posedge clk_sys_i);
    endclocking

    default disable iff (sys_rst_i);

    logic wr_ctrl;
    logic wr_en;

    assign wr_ctrl = reg_wr_i & hit_ctrl;
    assign wr_en   = reg_wr_i & hit_en;

    AST_EQ_STRENGTH: assert property (
        wr_ctrl |=> equalizer_strength_o == $past(reg_wdata_i[6:4]))
        else $error("equalizer strength does not follow control bits 6:4");

    AST_TX_BOOST: assert property (
        wr_ctrl |=> tx_dc_boost_o == $past(reg_wdata_i[3]))
        else $error("transmitter boost does not follow control bit 3");

    AST_EQ_DC_LEVEL: assert property (
        wr_ctrl |=> equalizer_dc_level_o == $past(reg_wdata_i[2]))
        else $error("equalizer DC level does not follow control bit 2");

    AST_RX_DECODE: assert property (
        wr_ctrl && reg_wdata_i[1:0] == 2'b11
        |=> ##1 rx_gain_level_o == LNECFG_RX_HIGH && rx_gain_pin_high_o
                && !rx_gain_pin_low_o && !rx_gain_pin_mid_o)
        else $error("receive gain code 11 did not select high");

    AST_RX_MID: assert property (
        wr_ctrl && reg_wdata_i[1:0] == 2'b01
        |=> ##1 rx_gain_level_o == LNECFG_RX_MID && rx_gain_pin_mid_o)
        else $error("receive gain code 01 did not select mid");

    AST_PEAKING: assert property (
        wr_en |=> driver_ac_peaking_o == $past(reg_wdata_i[2]))
        else $error("driver peaking does not follow enable bit 2");

    AST_EQ_OFF: assert property (
        wr_en |=> equalizer_stage_off_o == $past(reg_wdata_i[1]))
        else $error("equalizer stage off does not follow enable bit 1");

    AST_DRV_OFF: assert property (
        wr_en |=> driver_stage_off_o == $past(reg_wdata_i[0]))
        else $error("driver stage off does not follow enable bit 0");

    AST_EN_UPPER_ZERO: assert property (
        reg_rd_i && hit_en |=> reg_ack_o && reg_rdata_o[7:3] == 5'h00)
        else $error("enable bits 7:3 read nonzero");

    AST_RESET_ZERO: assert property (
        disable iff (1'b0)
        $fell(sys_rst_i) |-> gain_ctrl_r == 8'h00 && stage_en_r == 8'h00)
        else $error("registers not zero after reset");

    AST_RSVD_READBACK: assert property (
        wr_ctrl ##1 (reg_rd_i && hit_ctrl && !reg_wr_i)
        |=> reg_rdata_o[7] == $past(reg_wdata_i[7], 2))
        else $error("reserved control bit 7 did not read back");

    AST_CODE10_KEPT: assert property (
        wr_ctrl && reg_wdata_i[1:0] == 2'b10
        |=> rx_gain_code_o == 2'b10 ##1 rx_gain_level_o == LNECFG_RX_UNDEF)
        else $error("receive gain code 10 not stored");

    AST_HOLD_NO_WRITE: assert property (
        !reg_wr_i |=> $stable(gain_ctrl_r) && $stable(stage_en_r))
        else $error("register changed without a register write");

    AST_UNMAPPED: assert property (
        access && !hit_any |=> reg_ack_o && reg_err_o && reg_rdata_o == 8'h00)
        else $error("unmapped access not answered with error and zero");

    AST_ACK_ONE_CYCLE: assert property (
        !access |=> !reg_ack_o && !reg_err_o)
        else $error("acknowledge without an access");

    // whole-byte storage and the masked enable byte
    AST_CTRL_STORES_ALL: assert property (
        wr_ctrl |=> gain_ctrl_r == $past(reg_wdata_i))
        else $error("control register did not store the written byte");

    AST_EN_MASKED: assert property (
        wr_en |=> stage_en_r[7:3] == 5'h00
                  && stage_en_r[2:0] == $past(reg_wdata_i[2:0]))
        else $error("enable register did not store only its low three bits");

    AST_UNMAPPED_NO_STORE: assert property (
        reg_wr_i && !hit_any |=> $stable(gain_ctrl_r) && $stable(stage_en_r))
        else $error("write to an unmapped offset changed a register");

    // read port answers
    AST_CTRL_READ_VALUE: assert property (
        reg_rd_i && hit_ctrl && !reg_wr_i |=> reg_rdata_o[6:0] == {equalizer_strength_o,
            tx_dc_boost_o, equalizer_dc_level_o, rx_gain_code_o})
        else $error("control read does not match the field outputs");

    AST_EN_READ_VALUE: assert property (
        reg_rd_i && hit_en && !reg_wr_i |=> reg_rdata_o[2:0] == {driver_ac_peaking_o,
            equalizer_stage_off_o, driver_stage_off_o})
        else $error("enable read does not match the stage outputs");

    AST_MAPPED_NO_ERR: assert property (
        access && hit_any |=> reg_ack_o && !reg_err_o)
        else $error("mapped access answered with an error");

    AST_ACK_ON_ACCESS: assert property (
        access |=> reg_ack_o)
        else $error("access not acknowledged in the next cycle");

    AST_RD_WR_OLD_VALUE: assert property (
        reg_rd_i && wr_ctrl |=> reg_rdata_o == $past(gain_ctrl_r))
        else $error("read alongside a write did not return the old value");

    AST_RDATA_IDLE_ZERO: assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");

    AST_ERR_NEEDS_ACK: assert property (
        reg_err_o |-> reg_ack_o)
        else $error("error pulse without an acknowledge");

    // receive gain decoder, one cycle behind the code
    AST_RX_LOW: assert property (
        wr_ctrl && reg_wdata_i[1:0] == 2'b00
        |=> ##1 rx_gain_level_o == LNECFG_RX_LOW && rx_gain_pin_low_o
                && !rx_gain_pin_mid_o && !rx_gain_pin_high_o)
        else $error("receive gain code 00 did not select low");

    AST_PINS_LAG_CODE: assert property (
        1'b1 |=> rx_gain_pin_low_o == $past(rx_gain_code_o == 2'b00)
                 && rx_gain_pin_mid_o == $past(rx_gain_code_o == 2'b01)
                 && rx_gain_pin_high_o == $past(rx_gain_code_o == 2'b11))
        else $error("receive gain pins do not follow the stored code");

    AST_RX_PINS_ONEHOT: assert property (
        $onehot0({rx_gain_pin_low_o, rx_gain_pin_mid_o, rx_gain_pin_high_o}))
        else $error("more than one receive gain pin active");

    AST_CODE10_NO_PIN: assert property (
        rx_gain_level_o == LNECFG_RX_UNDEF
        |-> !rx_gain_pin_low_o && !rx_gain_pin_mid_o && !rx_gain_pin_high_o)
        else $error("undefined receive gain code drives a pin");

    // state seen at the first edge after reset is released
    AST_RESET_RX_LOW: assert property (
        disable iff (1'b0)
        $fell(sys_rst_i) |-> rx_gain_level_o == LNECFG_RX_LOW && rx_gain_pin_low_o)
        else $error("receive gain not low after reset");

    AST_RESET_PORT_QUIET: assert property (
        disable iff (1'b0)
        $fell(sys_rst_i) |-> !reg_ack_o && !reg_err_o && reg_rdata_o == 8'h00)
        else $error("register port not idle after reset");

    COV_WR_CTRL_RD: cover property (
        wr_ctrl ##1 (reg_rd_i && hit_ctrl));

    COV_STAGES_OFF: cover property (
        equalizer_stage_off_o && driver_stage_off_o);

    COV_UNITY_GAIN: cover property (
        equalizer_dc_level_o && rx_gain_level_o == LNECFG_RX_HIGH);

    COV_UNMAPPED: cover property (
        access && !hit_any);

    COV_CODE10_STORED: cover property (
        rx_gain_level_o == LNECFG_RX_UNDEF);

endmodule

/* File: design/lnecfg_cfg.svh */
/*
 * Offsets, field positions, reset values and codes of the lane 3
 * equalizer configuration register pair.
 * Assumes it is included by its bare name from the package and the design files.
 */
`ifndef LNECFG_CFG_SVH
`define LNECFG_CFG_SVH

// register offsets on the serial register port
`define LNECFG_ADDR_GAIN_CTRL    8'h0b
`define LNECFG_ADDR_STAGE_EN     8'h0c

// reset values
`define LNECFG_GAIN_CTRL_RST     8'h00
`define LNECFG_STAGE_EN_RST      8'h00

// gain control fields
`define LNECFG_CTL_RSVD_BIT      7
`define LNECFG_CTL_EQ_MSB        6
`define LNECFG_CTL_EQ_LSB        4
`define LNECFG_CTL_TXB_BIT       3
`define LNECFG_CTL_EQDC_BIT      2
`define LNECFG_CTL_RX_MSB        1
`define LNECFG_CTL_RX_LSB        0

// stage enable fields
`define LNECFG_EN_PEAK_BIT       2
`define LNECFG_EN_EQOFF_BIT      1
`define LNECFG_EN_DRVOFF_BIT     0
`define LNECFG_EN_WMASK          8'h07

// receive gain codes
`define LNECFG_RX_CODE_LOW       2'b00
`define LNECFG_RX_CODE_MID       2'b01
`define LNECFG_RX_CODE_UNDEF     2'b10
`define LNECFG_RX_CODE_HIGH      2'b11

// answer to a read of an unmapped offset
`define LNECFG_UNMAPPED_DATA     8'h00

`endif

/* File: design/lnecfg_pkg.sv */
/*
 * Types shared by the lane 3 equalizer configuration block.
 * Assumes lnecfg_cfg.svh is on the include path.
 */
`include "lnecfg_cfg.svh"

package lnecfg_pkg;

    // analog receive gain level selected by the two-bit code
    typedef enum logic [1:0] {
        LNECFG_RX_LOW,
        LNECFG_RX_MID,
        LNECFG_RX_HIGH,
        LNECFG_RX_UNDEF
    } lnecfg_rx_level_t;

    typedef logic [7:0] lnecfg_byte_t;

endpackage

/* File: design/lnecfg_rx_gain_dec.sv */
/*
 * Receive gain decoder: turns the two-bit gain code into a level and the
 * three-state drive that the matching control pin would give.
 * Assumes code_i comes from a register on the same clock.
 */
`timescale 1ns/100ps
`include "lnecfg_cfg.svh"

module lnecfg_rx_gain_dec
    import lnecfg_pkg::*;
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    input  wire logic [1:0]               code_i,
    output lnecfg_pkg::lnecfg_rx_level_t  level_o,
    output logic                          pin_low_o,
    output logic                          pin_mid_o,
    output logic                          pin_high_o
);
    import lnecfg_pkg::*;

    lnecfg_rx_level_t level_nxt;
    lnecfg_rx_level_t level_r;

    // code 10 has no defined setting; kept as its own level
    assign level_nxt = (code_i == `LNECFG_RX_CODE_LOW)  ? LNECFG_RX_LOW  :
                       (code_i == `LNECFG_RX_CODE_MID)  ? LNECFG_RX_MID  :
                       (code_i == `LNECFG_RX_CODE_HIGH) ? LNECFG_RX_HIGH :
                                                          LNECFG_RX_UNDEF;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            level_r    <= LNECFG_RX_LOW;
            pin_low_o  <= 1'b1;
            pin_mid_o  <= 1'b0;
            pin_high_o <= 1'b0;
        end
        else
        begin
            level_r    <= level_nxt;
            pin_low_o  <= (level_nxt == LNECFG_RX_LOW);
            pin_mid_o  <= (level_nxt == LNECFG_RX_MID);
            pin_high_o <= (level_nxt == LNECFG_RX_HIGH);
        end
    end

    assign level_o = level_r;

endmodule

/* File: dv/lnecfg_host_model.sv */
/*
 * Host model: issues one-cycle register strobes and collects the answer.
 * Assumes the register block answers on clk_sys_i with a one-cycle ack.
 */
`timescale 1ns/100ps

module lnecfg_host_model
(
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_ack_i,
    input  wire logic       reg_err_i,
    output logic [7:0]      reg_addr_o,
    output logic            reg_wr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_rd_o
);
    initial
    begin
        reg_addr_o = 8'h5a;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'ha5;
        reg_rd_o = 1'b0;
    end

    // one access; offset and data are scrambled once answered
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e, output logic ok);
        int n;
        ok = 1'b0;
        q = 8'h00;
        e = 1'b0;
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= wr;
        reg_rd_o <= ~wr;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            @(posedge clk_sys_i);
            if (reg_ack_i === 1'b1)
            begin
                ok = 1'b1;
                q = reg_rdata_i;
                e = reg_err_i;
            end
        end
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask

    // a write and then a read of one offset on consecutive edges
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = 8'h00;
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            @(posedge clk_sys_i);
            if (reg_ack_i === 1'b1)
            begin
                ok = 1'b1;
                q = reg_rdata_i;
            end
        end
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
endmodule

/* File: dv/test_lnecfg_lane_regs.sv */
/*
 * Self-checking bench for the lane 3 equalizer configuration registers.
 * Assumes the host model drives the strobe port; assertions sit in the design.
 */
`timescale 1ns/100ps

module test_lnecfg_lane_regs;
    import lnecfg_pkg::*;

    logic             clk_sys_i;
    logic             sys_rst_i;
    logic [7:0]       addr;
    logic             wr;
    logic [7:0]       wdata;
    logic             rd;
    logic [7:0]       rdata;
    logic             ack;
    logic             err;
    logic [2:0]       eq_str;
    logic             txb;
    logic             eqdc;
    logic [1:0]       code;
    lnecfg_rx_level_t lvl;
    logic             p_low;
    logic             p_mid;
    logic             p_high;
    logic             peak;
    logic             eqoff;
    logic             drvoff;
    logic [7:0]       q;
    logic [7:0]       v;
    logic             e;
    int               n_fail;
    int               num_checks;

    lnecfg_lane_regs #(.ADDR_W(8)) lnecfg_lane_regs_i (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
        .equalizer_strength_o(eq_str), .tx_dc_boost_o(txb), .equalizer_dc_level_o(eqdc),
        .rx_gain_code_o(code), .rx_gain_level_o(lvl), .rx_gain_pin_low_o(p_low),
        .rx_gain_pin_mid_o(p_mid), .rx_gain_pin_high_o(p_high),
        .driver_ac_peaking_o(peak), .equalizer_stage_off_o(eqoff),
        .driver_stage_off_o(drvoff));

    lnecfg_host_model lnecfg_host_model_i (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata),
        .reg_ack_i(ack), .reg_err_i(err), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rd_o(rd));

    always #5 clk_sys_i = ~clk_sys_i;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic ok;
        lnecfg_host_model_i.xfer(w, a, d, q, e, ok);
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("BAD ack expected 1 seen 0");
            report_and_stop();
        end
        else
            #1;
    endtask

    task automatic acc_wr_rd(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        lnecfg_host_model_i.wr_rd(a, d, q, ok);
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("BAD back to back ack expected 1 seen 0");
            report_and_stop();
        end
        else
            #1;
    endtask

    // field outputs and the decoded receive gain for a control value
    task automatic chk_ctrl(input logic [7:0] c);
        logic [1:0] x;
        x = c[1:0];
        chk("strength", {5'h00, c[6:4]}, {5'h00, eq_str});
        chk("tx boost", {7'h00, c[3]}, {7'h00, txb});
        chk("eq dc", {7'h00, c[2]}, {7'h00, eqdc});
        chk("rx code", {6'h00, x}, {6'h00, code});
        chk("rx level", {6'h00, x[1] ? (x[0] ? 2'd2 : 2'd3) : x}, {6'h00, lvl});
        chk("rx pins", {5'h00, x == 2'b11, x == 2'b01, x == 2'b00},
            {5'h00, p_high, p_mid, p_low});
    endtask

    initial
    begin
        clk_sys_i = 1'b0;
        sys_rst_i = 1'b1;
        n_fail = 0;
        num_checks = 0;
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1;
        chk_ctrl(8'h00);
        chk("stage bits", 8'h00, {5'h00, peak, eqoff, drvoff});
        acc(1'b0, 8'h0b, 8'h00);
        chk("ctrl reset", 8'h00, q);
        acc(1'b0, 8'h0c, 8'h00);
        chk("stage reset", 8'h00, q);
        $display("test reset values done");
        for (int i = 0; i < 8; i++)
        begin
            v = {i[0], i[2:0], ~i[0], i[1], i[1:0]};
            acc(1'b1, 8'h0b, v);
            chk_ctrl(v);
            acc(1'b0, 8'h0b, 8'h00);
            chk("ctrl read", v, q);
        end
        $display("test gain control done");
        for (int j = 0; j < 8; j++)
        begin
            acc(1'b1, 8'h0c, 8'hf8 | j[7:0]);
            chk("stage bits", j[7:0], {5'h00, peak, eqoff, drvoff});
            acc(1'b0, 8'h0c, 8'h00);
            chk("stage read", j[7:0], q);
            chk("mapped err", 8'h00, {7'h00, e});
        end
        $display("test stage enables done");
        acc(1'b1, 8'h0d, 8'hff);
        chk("unmapped wr err", 8'h01, {7'h00, e});
        acc(1'b0, 8'h00, 8'h00);
        chk("unmapped rd err", 8'h01, {7'h00, e});
        chk("unmapped rd data", 8'h00, q);
        acc(1'b0, 8'h0b, 8'h00);
        chk("ctrl kept", v, q);
        $display("test unmapped done");
        acc_wr_rd(8'h0b, 8'h8e);
        chk("ctrl back to back", 8'h8e, q);
        chk_ctrl(8'h8e);
        $display("test back to back done");
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1;
        chk_ctrl(8'h00);
        acc(1'b0, 8'h0c, 8'h00);
        chk("stage after reset", 8'h00, q);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
